// ===== include/scl_cfg.svh
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
`define SCL_ADDR_TXA_STAT 4'h1
`define SCL_ADDR_TXA_DYN 4'h2
`define SCL_ADDR_TXB_STAT 4'h4
`define SCL_ADDR_TXB_DYN 4'h5
`define SCL_ADDR_RXC_RATE 4'h6
`define SCL_ADDR_RXC_THR 4'h7
`define SCL_ADDR_RXD_RATE 4'h9
`define SCL_ADDR_RXD_THR 4'hA
`define SCL_BIT_TX_RATE 0
`define SCL_BIT_TX_CKSEL 1
`define SCL_BIT_RECENTER 0
`define SCL_BIT_PRI_EN 1
`define SCL_BIT_SEC_EN 2
`define SCL_BIT_SELFTEST 3
`define SCL_BIT_RX_RATE 0
`define SCL_LSB_PRI_THR 3
`define SCL_LSB_SEC_THR 5
`define SCL_RST_TX_RATE 1'h0
`define SCL_RST_TX_CKSEL 1'h1
`define SCL_RST_SELFTEST 1'h1
`define SCL_RST_DRV_EN 1'h0
`define SCL_RST_RECENTER 1'h1
`define SCL_RST_RX_RATE 1'h1
`define SCL_RST_THR 2'h2
`define SCL_TX_MULT_LOW 5'hA
`define SCL_TX_MULT_HIGH 5'h14
`define SCL_SYNC_STAGES 2
`endif

// ===== include/scl_pkg.sv
package scl_pkg;
  typedef logic [1:0] scl_thr_t;
  typedef enum logic [2:0] {
    SCL_TX_IDLE = 3'h1,
    SCL_TX_REQ = 3'h2,
    SCL_TX_WAIT = 3'h4
  } scl_rc_state_t;
endpackage

// ===== include/scl_wr_if.sv
`timescale 1ns/100ps
interface scl_wr_if;
  logic [3:0] addr;
  logic [7:0] data;
  logic strobe;
  modport src(output addr, output data, output strobe);
  modport dst(input addr, input data, input strobe);
endinterface

// ===== logic/scl_port_sync.sv
`timescale 1ns/100ps
`include "scl_cfg.svh"
module scl_port_sync #(
  parameter int WIDTH = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule

// ===== logic/scl_decode.sv
`timescale 1ns/100ps
`include "scl_cfg.svh"
module scl_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [12:0] pins_i,
  scl_wr_if.src wr
);
  // pins: [12:9] addr, [8:1] data, [0] write enable low
  logic en_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_d <= 1'b0;
      wr.strobe <= 1'b0;
      wr.addr <= 4'h0;
      wr.data <= 8'h00;
    end else begin
      en_d <= ~pins_i[0];
      // capture once per low phase of the write enable
      wr.strobe <= ~pins_i[0] & ~en_d;
      wr.addr <= pins_i[12:9];
      wr.data <= pins_i[8:1];
    end
  end
endmodule

// ===== logic/scl_channel_latches.sv
`timescale 1ns/100ps
`include "scl_cfg.svh"
module scl_channel_latches (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [3:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_DATA_I,
  input wire logic CONFIG_WRITE_STROBE_N_I,
  input wire logic [1:0] TX_INPUT_CLOCK_I,
  input wire logic [1:0] SPEED_RANGE_SELECT_I,
  output logic [1:0] TX_PLL_RATE_SELECT_O,
  output logic [9:0] TX_PLL_MULTIPLIER_O,
  output logic [1:0] TX_CLOCK_OUTPUT_DOUBLE_O,
  output logic [1:0] TX_CLOCK_SOURCE_SELECT_O,
  output logic [1:0] TX_DUAL_EDGE_CAPTURE_O,
  output logic [1:0] TX_PHASE_BUFFER_BYPASS_O,
  output logic [1:0] TX_RATE_CONFIG_INVALID_O,
  output logic [1:0] TX_SELFTEST_DISABLE_O,
  output logic [1:0] TX_PRIMARY_DRIVER_ENABLE_O,
  output logic [1:0] TX_SECONDARY_DRIVER_ENABLE_O,
  output logic [1:0] TX_PRIMARY_POWER_DOWN_O,
  output logic [1:0] TX_SECONDARY_POWER_DOWN_O,
  output logic [1:0] TX_CHANNEL_POWER_DOWN_O,
  output logic [1:0] PHASE_BUFFER_RECENTER_O,
  output logic [1:0] TX_RECENTER_PULSE_O,
  output logic [1:0] RX_CLOCK_RATE_SELECT_O,
  output logic [1:0] RX_CLOCK_HALF_RATE_O,
  output logic [3:0] PRIMARY_DETECT_THRESHOLD_O,
  output logic [3:0] SECONDARY_DETECT_THRESHOLD_O,
  output logic [1:0] PRIMARY_DETECT_DISABLE_O,
  output logic [1:0] SECONDARY_DETECT_DISABLE_O
);
  logic [12:0] pins_sync;
  logic [1:0] clk_sync;
  logic [1:0] spd_sync;
  scl_wr_if wr();

  logic [1:0] tx_rate;
  logic [1:0] tx_cksel;
  logic [1:0] selftest_dis;
  logic [1:0] pri_en;
  logic [1:0] sec_en;
  logic [1:0] recenter;
  logic [1:0] rx_rate;
  scl_pkg::scl_thr_t pri_thr [2];
  scl_pkg::scl_thr_t sec_thr [2];
  scl_pkg::scl_rc_state_t rc_state [2];
  logic [1:0] clk_prev;

  // pins are asynchronous to the system clock
  scl_port_sync #(.WIDTH(13)) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .d_i({CFG_ADDR_I, CFG_DATA_I, ~CONFIG_WRITE_STROBE_N_I}),
    .q_o(pins_sync)
  );

  scl_port_sync #(.WIDTH(4)) u_clk_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .d_i({TX_INPUT_CLOCK_I, SPEED_RANGE_SELECT_I}),
    .q_o({clk_sync, spd_sync})
  );

  logic [12:0] dec_pins;
  assign dec_pins = {pins_sync[12:1], ~pins_sync[0]};

  scl_decode u_decode (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .pins_i(dec_pins),
    .wr(wr.src)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
    hit = wr.strobe && (a == ref_a);
  endfunction

  function automatic logic [4:0] mult(input logic rate);
    mult = rate ? `SCL_TX_MULT_HIGH : `SCL_TX_MULT_LOW;
  endfunction

  // transmit static banks, one per channel
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      tx_rate <= {2{`SCL_RST_TX_RATE}};
      tx_cksel <= {2{`SCL_RST_TX_CKSEL}};
    end else begin
      if (hit(wr.addr, `SCL_ADDR_TXA_STAT)) begin
        tx_rate[0] <= wr.data[`SCL_BIT_TX_RATE];
        tx_cksel[0] <= wr.data[`SCL_BIT_TX_CKSEL];
      end
      if (hit(wr.addr, `SCL_ADDR_TXB_STAT)) begin
        tx_rate[1] <= wr.data[`SCL_BIT_TX_RATE];
        tx_cksel[1] <= wr.data[`SCL_BIT_TX_CKSEL];
      end
    end
  end

  // transmit dynamic banks; held otherwise
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      selftest_dis <= {2{`SCL_RST_SELFTEST}};
      pri_en <= {2{`SCL_RST_DRV_EN}};
      sec_en <= {2{`SCL_RST_DRV_EN}};
    end else begin
      if (hit(wr.addr, `SCL_ADDR_TXA_DYN)) begin
        selftest_dis[0] <= wr.data[`SCL_BIT_SELFTEST];
        pri_en[0] <= wr.data[`SCL_BIT_PRI_EN];
        sec_en[0] <= wr.data[`SCL_BIT_SEC_EN];
      end
      if (hit(wr.addr, `SCL_ADDR_TXB_DYN)) begin
        selftest_dis[1] <= wr.data[`SCL_BIT_SELFTEST];
        pri_en[1] <= wr.data[`SCL_BIT_PRI_EN];
        sec_en[1] <= wr.data[`SCL_BIT_SEC_EN];
      end
    end
  end

  // recentre latch: written zero, cleared back to one once the
  // transmit input clock has taken it
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      recenter <= {2{`SCL_RST_RECENTER}};
      rc_state[0] <= scl_pkg::SCL_TX_IDLE;
      rc_state[1] <= scl_pkg::SCL_TX_IDLE;
      clk_prev <= 2'h0;
      TX_RECENTER_PULSE_O <= 2'h0;
    end else begin
      clk_prev <= clk_sync;
      for (int ch = 0; ch < 2; ch++) begin
        TX_RECENTER_PULSE_O[ch] <= 1'b0;
        case (rc_state[ch])
          scl_pkg::SCL_TX_IDLE: begin
            if (hit(wr.addr, ch[0] ? `SCL_ADDR_TXB_DYN : `SCL_ADDR_TXA_DYN)
                && !wr.data[`SCL_BIT_RECENTER]) begin
              recenter[ch] <= 1'b0;
              rc_state[ch] <= scl_pkg::SCL_TX_REQ;
            end
          end
          scl_pkg::SCL_TX_REQ: begin
            // sampled on a rising transmit input clock edge
            if (clk_sync[ch] && !clk_prev[ch]) begin
              TX_RECENTER_PULSE_O[ch] <= 1'b1;
              rc_state[ch] <= scl_pkg::SCL_TX_WAIT;
            end
          end
          scl_pkg::SCL_TX_WAIT: begin
            recenter[ch] <= 1'b1;
            rc_state[ch] <= scl_pkg::SCL_TX_IDLE;
          end
          default: begin
            recenter[ch] <= 1'b1;
            rc_state[ch] <= scl_pkg::SCL_TX_IDLE;
          end
        endcase
      end
    end
  end

  // receive banks
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      rx_rate <= {2{`SCL_RST_RX_RATE}};
      pri_thr[0] <= `SCL_RST_THR;
      pri_thr[1] <= `SCL_RST_THR;
      sec_thr[0] <= `SCL_RST_THR;
      sec_thr[1] <= `SCL_RST_THR;
    end else begin
      if (hit(wr.addr, `SCL_ADDR_RXC_RATE))
        rx_rate[0] <= wr.data[`SCL_BIT_RX_RATE];
      if (hit(wr.addr, `SCL_ADDR_RXD_RATE))
        rx_rate[1] <= wr.data[`SCL_BIT_RX_RATE];
      if (hit(wr.addr, `SCL_ADDR_RXC_THR)) begin
        pri_thr[0] <= wr.data[`SCL_LSB_PRI_THR +: 2];
        sec_thr[0] <= wr.data[`SCL_LSB_SEC_THR +: 2];
      end
      if (hit(wr.addr, `SCL_ADDR_RXD_THR)) begin
        pri_thr[1] <= wr.data[`SCL_LSB_PRI_THR +: 2];
        sec_thr[1] <= wr.data[`SCL_LSB_SEC_THR +: 2];
      end
    end
  end

  // derived controls, registered so every output is a flop
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      TX_PLL_RATE_SELECT_O <= 2'h0;
      TX_PLL_MULTIPLIER_O <= {`SCL_TX_MULT_LOW, `SCL_TX_MULT_LOW};
      TX_CLOCK_OUTPUT_DOUBLE_O <= 2'h0;
      TX_CLOCK_SOURCE_SELECT_O <= 2'h3;
      TX_DUAL_EDGE_CAPTURE_O <= 2'h0;
      TX_PHASE_BUFFER_BYPASS_O <= 2'h3;
      TX_RATE_CONFIG_INVALID_O <= 2'h0;
      TX_SELFTEST_DISABLE_O <= 2'h3;
      TX_PRIMARY_DRIVER_ENABLE_O <= 2'h0;
      TX_SECONDARY_DRIVER_ENABLE_O <= 2'h0;
      TX_PRIMARY_POWER_DOWN_O <= 2'h3;
      TX_SECONDARY_POWER_DOWN_O <= 2'h3;
      TX_CHANNEL_POWER_DOWN_O <= 2'h3;
      PHASE_BUFFER_RECENTER_O <= 2'h3;
      RX_CLOCK_RATE_SELECT_O <= 2'h3;
      RX_CLOCK_HALF_RATE_O <= 2'h3;
      PRIMARY_DETECT_THRESHOLD_O <= 4'hA;
      SECONDARY_DETECT_THRESHOLD_O <= 4'hA;
      PRIMARY_DETECT_DISABLE_O <= 2'h0;
      SECONDARY_DETECT_DISABLE_O <= 2'h0;
    end else begin
      TX_PLL_RATE_SELECT_O <= tx_rate;
      // x10 when clear, x20 when set
      TX_PLL_MULTIPLIER_O <= {mult(tx_rate[1]), mult(tx_rate[0])};
      TX_CLOCK_OUTPUT_DOUBLE_O <= tx_rate;
      TX_CLOCK_SOURCE_SELECT_O <= tx_cksel;
      TX_DUAL_EDGE_CAPTURE_O <= tx_cksel & tx_rate;
      TX_PHASE_BUFFER_BYPASS_O <= tx_cksel;
      // flag only; the controller must not set this pairing
      TX_RATE_CONFIG_INVALID_O <= tx_rate & ~spd_sync;
      TX_SELFTEST_DISABLE_O <= selftest_dis;
      TX_PRIMARY_DRIVER_ENABLE_O <= pri_en;
      TX_SECONDARY_DRIVER_ENABLE_O <= sec_en;
      TX_PRIMARY_POWER_DOWN_O <= ~pri_en;
      TX_SECONDARY_POWER_DOWN_O <= ~sec_en;
      TX_CHANNEL_POWER_DOWN_O <= ~pri_en & ~sec_en;
      PHASE_BUFFER_RECENTER_O <= recenter;
      RX_CLOCK_RATE_SELECT_O <= rx_rate;
      RX_CLOCK_HALF_RATE_O <= rx_rate;
      PRIMARY_DETECT_THRESHOLD_O <= {pri_thr[1], pri_thr[0]};
      SECONDARY_DETECT_THRESHOLD_O <= {sec_thr[1], sec_thr[0]};
      PRIMARY_DETECT_DISABLE_O <= {pri_thr[1] == 2'h0, pri_thr[0] == 2'h0};
      SECONDARY_DETECT_DISABLE_O <= {sec_thr[1] == 2'h0,
                                     sec_thr[0] == 2'h0};
    end
  end
endmodule

// ===== verification/scl_channel_latches_sva.sv
`timescale 1ns/100ps
module scl_channel_latches_sva (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [3:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_DATA_I,
  input wire logic CONFIG_WRITE_STROBE_N_I,
  input wire logic [1:0] TX_PLL_RATE_SELECT_O,
  input wire logic [9:0] TX_PLL_MULTIPLIER_O,
  input wire logic [1:0] TX_CLOCK_SOURCE_SELECT_O,
  input wire logic [1:0] TX_DUAL_EDGE_CAPTURE_O,
  input wire logic [1:0] TX_SELFTEST_DISABLE_O,
  input wire logic [1:0] TX_PRIMARY_DRIVER_ENABLE_O,
  input wire logic [1:0] TX_SECONDARY_DRIVER_ENABLE_O,
  input wire logic [1:0] TX_CHANNEL_POWER_DOWN_O,
  input wire logic [1:0] PHASE_BUFFER_RECENTER_O,
  input wire logic [1:0] TX_RECENTER_PULSE_O,
  input wire logic [3:0] PRIMARY_DETECT_THRESHOLD_O,
  input wire logic [1:0] PRIMARY_DETECT_DISABLE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic [1:0] rt = TX_PLL_RATE_SELECT_O;
  wire logic [1:0] pe = TX_PRIMARY_DRIVER_ENABLE_O;
  wire logic [1:0] se = TX_SECONDARY_DRIVER_ENABLE_O;
  wire logic [11:0] cfg = {rt, TX_CLOCK_SOURCE_SELECT_O, pe, se,
    TX_SELFTEST_DISABLE_O, PRIMARY_DETECT_THRESHOLD_O[1:0]};
  // reset must win even over a write in flight
  rst_vals_a: assert property (
    disable iff (1'b0) RESET_I ##1 RESET_I
    |-> {rt, TX_SELFTEST_DISABLE_O, pe, se} == 8'h30)
    else $error("latches not at reset values");
  mult_sel_a: assert property (
    TX_PLL_MULTIPLIER_O[4:0] == (rt[0] ? 5'h14 : 5'h0A))
    else $error("multiplier disagrees with rate");
  dual_edge_a: assert property (
    TX_DUAL_EDGE_CAPTURE_O == (TX_CLOCK_SOURCE_SELECT_O & rt))
    else $error("dual edge wrong");
  chan_pd_a: assert property (
    TX_CHANNEL_POWER_DOWN_O == ~(pe | se))
    else $error("channel power down wrong");
  det_off_a: assert property (
    PRIMARY_DETECT_DISABLE_O[0] == (PRIMARY_DETECT_THRESHOLD_O[1:0] == 2'h0))
    else $error("detector off wrong");
  hold_val_a: assert property (
    CONFIG_WRITE_STROBE_N_I [*8] |=> $stable(cfg))
    else $error("latch moved without a write");
  wr_lat_a: assert property (
    $fell(CONFIG_WRITE_STROBE_N_I) && CFG_ADDR_I == 4'h1
    |-> ##7 rt[0] == $past(CFG_DATA_I[0], 7))
    else $error("rate write not taken");
  thr_lat_a: assert property (
    $fell(CONFIG_WRITE_STROBE_N_I) && CFG_ADDR_I == 4'h7
    |-> ##7 PRIMARY_DETECT_THRESHOLD_O[1:0] == $past(CFG_DATA_I[4:3], 7))
    else $error("threshold write not taken");
  pulse_once_a: assert property (
    TX_RECENTER_PULSE_O[0] |=>
    !TX_RECENTER_PULSE_O[0] ##[0:1] PHASE_BUFFER_RECENTER_O[0])
    else $error("recentre did not clear");
  cover property (TX_RECENTER_PULSE_O[0]);
  cover property (TX_CHANNEL_POWER_DOWN_O[0] && !RESET_I);
  cover property (PRIMARY_DETECT_DISABLE_O[0]);
endmodule
bind scl_channel_latches scl_channel_latches_sva chk_u (.*);

// ===== verification/scl_cfg_ctrl.sv
`timescale 1ns/100ps
module scl_cfg_ctrl (
  input wire logic clk_i,
  output logic [3:0] addr_o,
  output logic [7:0] data_o,
  output logic wr_n_o
);
  initial addr_o = 4'h0;
  initial data_o = 8'h00;
  initial wr_n_o = 1'b1;
  // low phase held well past the input sync pipe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    wr_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    wr_n_o <= 1'b1;
    data_o <= ~d;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] txc = 2'h0;
  // channel b low speed, but its rate stays clear
  logic [1:0] spd = 2'h1;
  logic [3:0] a;
  logic [7:0] d;
  logic wn;
  int err_total = 0;
  int comparisons = 0;
  int pulses = 0;
  int un[3] = '{0, 8, 15};
  initial forever #5 clk = ~clk;
  scl_cfg_ctrl ctl_u (.clk_i(clk), .addr_o(a), .data_o(d), .wr_n_o(wn));
  scl_channel_latches dut_u (.SYS_CLK_I(clk), .RESET_I(rst),
    .CFG_ADDR_I(a), .CFG_DATA_I(d), .CONFIG_WRITE_STROBE_N_I(wn),
    .TX_INPUT_CLOCK_I(txc), .SPEED_RANGE_SELECT_I(spd),
    .TX_PLL_RATE_SELECT_O(), .TX_PLL_MULTIPLIER_O(),
    .TX_CLOCK_OUTPUT_DOUBLE_O(), .TX_CLOCK_SOURCE_SELECT_O(),
    .TX_DUAL_EDGE_CAPTURE_O(), .TX_PHASE_BUFFER_BYPASS_O(),
    .TX_RATE_CONFIG_INVALID_O(), .TX_SELFTEST_DISABLE_O(),
    .TX_PRIMARY_DRIVER_ENABLE_O(), .TX_SECONDARY_DRIVER_ENABLE_O(),
    .TX_PRIMARY_POWER_DOWN_O(), .TX_SECONDARY_POWER_DOWN_O(),
    .TX_CHANNEL_POWER_DOWN_O(), .PHASE_BUFFER_RECENTER_O(),
    .TX_RECENTER_PULSE_O(), .RX_CLOCK_RATE_SELECT_O(),
    .RX_CLOCK_HALF_RATE_O(), .PRIMARY_DETECT_THRESHOLD_O(),
    .SECONDARY_DETECT_THRESHOLD_O(), .PRIMARY_DETECT_DISABLE_O(),
    .SECONDARY_DETECT_DISABLE_O());
  always @(posedge clk) if (dut_u.TX_RECENTER_PULSE_O[0] === 1'b1) pulses++;
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("rate", dut_u.TX_PLL_RATE_SELECT_O, 10'h0);
    chk("mult", dut_u.TX_PLL_MULTIPLIER_O, 10'h14A);
    chk("selftest", dut_u.TX_SELFTEST_DISABLE_O, 10'h3);
    chk("pri_en", dut_u.TX_PRIMARY_DRIVER_ENABLE_O, 10'h0);
    chk("sec_en", dut_u.TX_SECONDARY_DRIVER_ENABLE_O, 10'h0);
    chk("chan_pd", dut_u.TX_CHANNEL_POWER_DOWN_O, 10'h3);
    chk("cksel", dut_u.TX_CLOCK_SOURCE_SELECT_O, 10'h3);
    chk("recentre", dut_u.PHASE_BUFFER_RECENTER_O, 10'h3);
    chk("rx_rate", dut_u.RX_CLOCK_HALF_RATE_O, 10'h3);
    chk("pri_thr", dut_u.PRIMARY_DETECT_THRESHOLD_O, 10'hA);
    chk("sec_thr", dut_u.SECONDARY_DETECT_THRESHOLD_O, 10'hA);
    ctl_u.wr(4'h1, 8'h03);
    ctl_u.wr(4'h4, 8'h00);
    chk("mult", dut_u.TX_PLL_MULTIPLIER_O, 10'h154);
    chk("dual", dut_u.TX_DUAL_EDGE_CAPTURE_O, 10'h1);
    chk("bypass", dut_u.TX_PHASE_BUFFER_BYPASS_O, 10'h1);
    chk("cksel", dut_u.TX_CLOCK_SOURCE_SELECT_O, 10'h1);
    chk("double", dut_u.TX_CLOCK_OUTPUT_DOUBLE_O, 10'h1);
    chk("invalid", dut_u.TX_RATE_CONFIG_INVALID_O, 10'h0);
    ctl_u.wr(4'h2, 8'h03);
    ctl_u.wr(4'h5, 8'h05);
    chk("selftest", dut_u.TX_SELFTEST_DISABLE_O, 10'h0);
    chk("pri_pd", dut_u.TX_PRIMARY_POWER_DOWN_O, 10'h2);
    chk("sec_pd", dut_u.TX_SECONDARY_POWER_DOWN_O, 10'h1);
    chk("chan_pd", dut_u.TX_CHANNEL_POWER_DOWN_O, 10'h0);
    ctl_u.wr(4'h2, 8'h09);
    chk("chan_pd", dut_u.TX_CHANNEL_POWER_DOWN_O, 10'h1);
    ctl_u.wr(4'h6, 8'h00);
    chk("rx_rate", dut_u.RX_CLOCK_RATE_SELECT_O, 10'h2);
    for (int i = 0; i < 4; i++) begin
      ctl_u.wr(4'h7, {1'b0, 2'(3 - i), 2'(i), 3'h0});
      chk("pri_thr", dut_u.PRIMARY_DETECT_THRESHOLD_O, 10'(8 + i));
      chk("sec_thr", dut_u.SECONDARY_DETECT_THRESHOLD_O,
        10'(11 - i));
      chk("pri_off", dut_u.PRIMARY_DETECT_DISABLE_O, 10'(i == 0));
      chk("sec_off", dut_u.SECONDARY_DETECT_DISABLE_O,
        10'(i == 3));
    end
    ctl_u.wr(4'hA, 8'h18);
    chk("pri_thr", dut_u.PRIMARY_DETECT_THRESHOLD_O, 10'hF);
    chk("sec_off", dut_u.SECONDARY_DETECT_DISABLE_O, 10'h3);
    // unmapped banks must leave every latch alone
    foreach (un[i]) ctl_u.wr(4'(un[i]), 8'hFF);
    chk("rate", dut_u.TX_PLL_RATE_SELECT_O, 10'h1);
    chk("pri_en", dut_u.TX_PRIMARY_DRIVER_ENABLE_O, 10'h0);
    chk("rx_rate", dut_u.RX_CLOCK_RATE_SELECT_O, 10'h2);
    ctl_u.wr(4'h2, 8'h0E);
    chk("pending", dut_u.PHASE_BUFFER_RECENTER_O, 10'h2);
    chk("pulses", 10'(pulses), 10'h0);
    txc <= 2'h1;
    repeat (8) @(posedge clk);
    chk("pulses", 10'(pulses), 10'h1);
    chk("recentre", dut_u.PHASE_BUFFER_RECENTER_O, 10'h3);
    chk("pri_en", dut_u.TX_PRIMARY_DRIVER_ENABLE_O, 10'h1);
    chk("sec_en", dut_u.TX_SECONDARY_DRIVER_ENABLE_O, 10'h3);
    txc <= 2'h0;
    // a second reset must undo every written latch
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("rate", dut_u.TX_PLL_RATE_SELECT_O, 10'h0);
    chk("pri_en", dut_u.TX_PRIMARY_DRIVER_ENABLE_O, 10'h0);
    chk("sec_en", dut_u.TX_SECONDARY_DRIVER_ENABLE_O, 10'h0);
    chk("rx_rate", dut_u.RX_CLOCK_RATE_SELECT_O, 10'h3);
    chk("pri_thr", dut_u.PRIMARY_DETECT_THRESHOLD_O, 10'hA);
    tally_and_finish;
  end
endmodule
